// file: hw/seim_top.sv
// seim_top: interrupt enable, event mode and status flag logic
`timescale 1ns/1ns
`default_nettype none
module seim_top
    import seim_pkg::*;
#(
    parameter bit LATE_SEQ = 1'b1
) (
    // system clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_arst_n,
    // register port from the serial engine, link clock domain
    input  wire logic                          i_link_clk,
    input  wire logic                          i_link_wr,
    input  wire logic                          i_link_rd,
    input  wire logic [7:0]                    i_link_addr,
    input  wire logic [7:0]                    i_link_wdata,
    output logic      [7:0]                    o_link_rdata,
    output logic                               o_link_busy,
    // proximity events and thresholds
    input  wire seim_meas_t [SEIM_NPROX-1:0]   i_prox,
    input  wire logic [SEIM_NPROX-1:0][SEIM_DW-1:0] i_prox_thr,
    // ambient events and window bounds
    input  wire seim_meas_t                    i_amb_vis,
    input  wire seim_meas_t                    i_amb_ir,
    input  wire logic [SEIM_DW-1:0]            i_amb_low,
    input  wire logic [SEIM_DW-1:0]            i_amb_high,
    // response register writes
    input  wire logic                          i_resp_wr,
    input  wire logic [7:0]                    i_resp_data,
    // open-drain interrupt pin
    output logic                               o_int_out,
    output logic                               o_int_oe,
    // flags for the sequencer
    output logic      [SEIM_NFLAG-1:0]         o_flags
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]            cfg;
        logic [7:0]            enable;
        logic [7:0]            mode_a;
        logic [7:0]            mode_b;
        logic [SEIM_NFLAG-1:0] flags;
        logic [SEIM_NPROX-1:0] above;
        logic                  in_vis;
        logic                  in_ir;
        logic                  int_oe;
        logic                  int_out;
    } seim_sys_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] enable;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [7:0] rdata;
        logic       busy;
    } seim_lnk_t;

    seim_sys_t sys_reg;
    seim_sys_t sys_next;
    seim_lnk_t lnk_reg;
    seim_lnk_t lnk_next;

    logic                  lnk_accept;
    logic                  wr_ready;
    logic                  wr_valid;
    seim_wr_t              wr_word;
    seim_wr_t              wr_src;
    logic                  st_ready;
    logic                  st_valid;
    logic [SEIM_NFLAG-1:0] st_mirror;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // mode field of one proximity channel
    function automatic seim_pmode_t prox_mode(
        input int         ch,
        input logic [7:0] ma,
        input logic [7:0] mb
    );
        case (ch)
            0:       prox_mode = seim_pmode_t'(ma[SEIM_MA_PROX1_LO +: 2]);
            1:       prox_mode = seim_pmode_t'(ma[SEIM_MA_PROX2_LO +: 2]);
            default: prox_mode = seim_pmode_t'(mb[SEIM_MB_PROX3_LO +: 2]);
        endcase
    endfunction

    function automatic logic in_window(input logic [SEIM_DW-1:0] v,
                                       input logic [SEIM_DW-1:0] lo,
                                       input logic [SEIM_DW-1:0] hi);
        in_window = (v >= lo) && (v <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // crossings: writes go to the system clock, flags come back

    assign wr_src.addr = i_link_addr;
    assign wr_src.data = i_link_wdata;

    // a write is taken only while the last one has landed
    assign lnk_accept = i_link_wr && !lnk_reg.busy;

    seim_xfer #(.W($bits(seim_wr_t))) u_wr_xfer (
        .i_src_clk   (i_link_clk),
        .i_arst_n    (i_arst_n),
        .i_src_valid (lnk_accept),
        .i_src_data  (wr_src),
        .o_src_ready (wr_ready),
        .i_dst_clk   (i_clk),
        .o_dst_valid (wr_valid),
        .o_dst_data  (wr_word)
    );

    // flags are streamed back continuously; the mirror lags by a few edges
    seim_xfer #(.W(SEIM_NFLAG)) u_st_xfer (
        .i_src_clk   (i_clk),
        .i_arst_n    (i_arst_n),
        .i_src_valid (st_ready),
        .i_src_data  (sys_reg.flags),
        .o_src_ready (st_ready),
        .i_dst_clk   (i_link_clk),
        .o_dst_valid (st_valid),
        .o_dst_data  (st_mirror)
    );

    ////////////////////////////////////////////////////////////////////////
    // link domain: register mirror, read data, busy

    always_comb begin
        lnk_next      = lnk_reg;
        lnk_next.busy = lnk_accept || !wr_ready;
        if (lnk_accept) begin
            case (i_link_addr)
                SEIM_OFF_CFG:
                    lnk_next.cfg = i_link_wdata & seim_wmask(i_link_addr);
                SEIM_OFF_ENABLE:
                    lnk_next.enable = i_link_wdata & seim_wmask(i_link_addr);
                SEIM_OFF_MODE_A:
                    lnk_next.mode_a = i_link_wdata & seim_wmask(i_link_addr);
                SEIM_OFF_MODE_B:
                    lnk_next.mode_b = i_link_wdata & seim_wmask(i_link_addr);
                default: begin
                end
            endcase
        end
        if (i_link_rd) begin
            case (i_link_addr)
                SEIM_OFF_CFG:    lnk_next.rdata = lnk_reg.cfg;
                SEIM_OFF_ENABLE: lnk_next.rdata = lnk_reg.enable;
                SEIM_OFF_MODE_A: lnk_next.rdata = lnk_reg.mode_a;
                SEIM_OFF_MODE_B: lnk_next.rdata = lnk_reg.mode_b;
                SEIM_OFF_STATUS: lnk_next.rdata = {2'b00, st_mirror};
                default:         lnk_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lnk_reg        <= '0;
            lnk_reg.cfg    <= SEIM_RST_CFG;
            lnk_reg.enable <= SEIM_RST_ENABLE;
            lnk_reg.mode_a <= SEIM_RST_MODE_A;
            lnk_reg.mode_b <= SEIM_RST_MODE_B;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system domain: registers, flag setting, interrupt pin

    always_comb begin
        logic [SEIM_NFLAG-1:0] set_v;
        logic [SEIM_NFLAG-1:0] clr_v;
        logic [2:0]            amode;
        logic [1:0]            aen;
        logic                  above_now;
        logic                  vis_in;
        logic                  ir_in;
        seim_pmode_t           pm;
        set_v     = '0;
        clr_v     = '0;
        above_now = 1'b0;
        pm        = SEIM_PM_DONE;
        amode  = sys_reg.mode_a[SEIM_MA_AMB_LO +: 3];
        aen    = sys_reg.enable[SEIM_FLG_AMB0 +: 2];
        vis_in = in_window(i_amb_vis.value, i_amb_low, i_amb_high);
        ir_in  = in_window(i_amb_ir.value, i_amb_low, i_amb_high);
        sys_next  = sys_reg;

        // register writes; status bits clear where a one is written
        if (wr_valid) begin
            case (wr_word.addr)
                SEIM_OFF_CFG:
                    sys_next.cfg = wr_word.data & seim_wmask(wr_word.addr);
                SEIM_OFF_ENABLE:
                    sys_next.enable = wr_word.data & seim_wmask(wr_word.addr);
                SEIM_OFF_MODE_A:
                    sys_next.mode_a = wr_word.data & seim_wmask(wr_word.addr);
                SEIM_OFF_MODE_B:
                    sys_next.mode_b = wr_word.data & seim_wmask(wr_word.addr);
                SEIM_OFF_STATUS:
                    clr_v = wr_word.data[SEIM_NFLAG-1:0];
                default: begin
                end
            endcase
        end

        // proximity channels
        for (int ch = 0; ch < SEIM_NPROX; ch++) begin
            pm        = prox_mode(ch, sys_reg.mode_a, sys_reg.mode_b);
            above_now = i_prox[ch].value > i_prox_thr[ch];
            if (i_prox[ch].done) begin
                sys_next.above[ch] = above_now;
                // mode only sets the flag while the channel is enabled
                if (sys_reg.enable[SEIM_FLG_PROX1 + ch]) begin
                    case (pm)
                        SEIM_PM_DONE:
                            set_v[SEIM_FLG_PROX1 + ch] = 1'b1;
                        SEIM_PM_CROSS:
                            set_v[SEIM_FLG_PROX1 + ch] =
                                above_now != sys_reg.above[ch];
                        SEIM_PM_ABOVE:
                            set_v[SEIM_FLG_PROX1 + ch] = above_now;
                        default:
                            set_v[SEIM_FLG_PROX1 + ch] = 1'b0;
                    endcase
                end
                // auto-release mode drops an above flag once below again
                if (sys_reg.cfg[SEIM_CFG_MODE] && pm == SEIM_PM_ABOVE &&
                    !above_now) begin
                    clr_v[SEIM_FLG_PROX1 + ch] = 1'b1;
                end
            end
        end

        // ambient channel; window modes exist only on the later sequencer
        if (i_amb_vis.done) begin
            sys_next.in_vis = vis_in;
        end
        if (i_amb_ir.done) begin
            sys_next.in_ir = ir_in;
        end
        if (aen[0] && amode == 3'b000 && i_amb_vis.done) begin
            set_v[SEIM_FLG_AMB0] = 1'b1;
        end
        if (LATE_SEQ && aen[0] && amode[1:0] == 2'b01 &&
            i_amb_vis.done && sys_reg.in_vis && !vis_in) begin
            set_v[SEIM_FLG_AMB0] = 1'b1;
        end
        if (LATE_SEQ && aen[0] && amode[1:0] == 2'b11 &&
            i_amb_ir.done && sys_reg.in_ir && !ir_in) begin
            set_v[SEIM_FLG_AMB0] = 1'b1;
        end
        if (LATE_SEQ && aen[1] && amode[2:1] == 2'b10 &&
            i_amb_vis.done && !sys_reg.in_vis && vis_in) begin
            set_v[SEIM_FLG_AMB1] = 1'b1;
        end
        if (LATE_SEQ && aen[1] && amode[2:1] == 2'b11 &&
            i_amb_ir.done && !sys_reg.in_ir && ir_in) begin
            set_v[SEIM_FLG_AMB1] = 1'b1;
        end

        // command channel; reserved codes never flag
        if (i_resp_wr && sys_reg.enable[SEIM_FLG_CMD]) begin
            case (sys_reg.mode_b[SEIM_MB_CMD_LO +: 2])
                SEIM_CM_ANY:
                    set_v[SEIM_FLG_CMD] = 1'b1;
                SEIM_CM_ERR:
                    set_v[SEIM_FLG_CMD] = i_resp_data[7];
                default:
                    set_v[SEIM_FLG_CMD] = 1'b0;
            endcase
        end

        // sticky flags; a new event beats a clear in the same cycle
        sys_next.flags = (sys_reg.flags & ~clr_v) | set_v;

        // pin pulls low while the OE bit is set and any flag meets its enable bit
        sys_next.int_out = 1'b0;
        sys_next.int_oe  = sys_reg.cfg[SEIM_CFG_OE] &&
            |(sys_reg.flags &
              sys_reg.enable[SEIM_NFLAG-1:0]);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sys_reg        <= '0;
            sys_reg.cfg    <= SEIM_RST_CFG;
            sys_reg.enable <= SEIM_RST_ENABLE;
            sys_reg.mode_a <= SEIM_RST_MODE_A;
            sys_reg.mode_b <= SEIM_RST_MODE_B;
        end else begin
            sys_reg <= sys_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_link_rdata = lnk_reg.rdata;
    assign o_link_busy  = lnk_reg.busy;
    assign o_int_out    = sys_reg.int_out;
    assign o_int_oe     = sys_reg.int_oe;
    assign o_flags      = sys_reg.flags;

endmodule // seim_top
`default_nettype wire

// file: include/seim_pkg.sv
// seim_pkg: register map, field layout and carrier types of the event logic
package seim_pkg;

    // register offsets
    localparam logic [7:0] SEIM_OFF_CFG    = 8'h03;
    localparam logic [7:0] SEIM_OFF_ENABLE = 8'h04;
    localparam logic [7:0] SEIM_OFF_MODE_A = 8'h05;
    localparam logic [7:0] SEIM_OFF_MODE_B = 8'h06;
    localparam logic [7:0] SEIM_OFF_STATUS = 8'h21;

    // reset values and writable-bit masks
    localparam logic [7:0] SEIM_RST_CFG    = 8'h00;
    localparam logic [7:0] SEIM_RST_ENABLE = 8'h00;
    localparam logic [7:0] SEIM_RST_MODE_A = 8'h00;
    localparam logic [7:0] SEIM_RST_MODE_B = 8'h00;
    localparam logic [7:0] SEIM_MSK_CFG    = 8'h03;
    localparam logic [7:0] SEIM_MSK_ENABLE = 8'h3F;
    localparam logic [7:0] SEIM_MSK_MODE_A = 8'hF7;
    localparam logic [7:0] SEIM_MSK_MODE_B = 8'h0F;
    localparam logic [7:0] SEIM_MSK_STATUS = 8'h3F;

    // field positions
    localparam int SEIM_CFG_OE     = 0;
    localparam int SEIM_CFG_MODE   = 1;
    localparam int SEIM_FLG_AMB0   = 0;
    localparam int SEIM_FLG_AMB1   = 1;
    localparam int SEIM_FLG_PROX1  = 2;
    localparam int SEIM_FLG_CMD    = 5;
    localparam int SEIM_MA_PROX2_LO = 6;
    localparam int SEIM_MA_PROX1_LO = 4;
    localparam int SEIM_MA_AMB_LO   = 0;
    localparam int SEIM_MB_CMD_LO   = 2;
    localparam int SEIM_MB_PROX3_LO = 0;
    localparam int SEIM_NFLAG      = 6;
    localparam int SEIM_NPROX      = 3;
    localparam int SEIM_DW         = 16;
    localparam int SEIM_SYNC_STAGES = 2;

    // proximity and command mode codes
    typedef enum logic [1:0] {
        SEIM_PM_DONE  = 2'b00,
        SEIM_PM_CROSS = 2'b01,
        SEIM_PM_RSVD  = 2'b10,
        SEIM_PM_ABOVE = 2'b11
    } seim_pmode_t;

    typedef enum logic [1:0] {
        SEIM_CM_ANY = 2'b00,
        SEIM_CM_ERR = 2'b01
    } seim_cmode_t;

    // register write carried across the clock boundary
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } seim_wr_t;

    // one measurement event from the sequencer
    typedef struct packed {
        logic                done;
        logic [SEIM_DW-1:0]  value;
    } seim_meas_t;

    // writable bits of an offset, zero for unmapped addresses
    function automatic logic [7:0] seim_wmask(input logic [7:0] addr);
        case (addr)
            SEIM_OFF_CFG:    seim_wmask = SEIM_MSK_CFG;
            SEIM_OFF_ENABLE: seim_wmask = SEIM_MSK_ENABLE;
            SEIM_OFF_MODE_A: seim_wmask = SEIM_MSK_MODE_A;
            SEIM_OFF_MODE_B: seim_wmask = SEIM_MSK_MODE_B;
            SEIM_OFF_STATUS: seim_wmask = SEIM_MSK_STATUS;
            default:         seim_wmask = 8'h00;
        endcase
    endfunction

endpackage

// file: hw/seim_sync.sv
// seim_sync: two-stage synchroniser for levels
`timescale 1ns/1ns
`default_nettype none
module seim_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } seim_sync_st_t;

    seim_sync_st_t st_reg;
    seim_sync_st_t st_next;

    // first stage feeds only the second
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = i_d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_q = st_reg.s2;
endmodule // seim_sync
`default_nettype wire

// file: hw/seim_xfer.sv
// seim_xfer: toggle handshake carrying one word between two clocks
`timescale 1ns/1ns
`default_nettype none
module seim_xfer #(
    parameter int W = 8
) (
    // source side
    input  wire logic         i_src_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_src_valid,
    input  wire logic [W-1:0] i_src_data,
    output logic              o_src_ready,
    // destination side
    input  wire logic         i_dst_clk,
    output logic              o_dst_valid,
    output logic      [W-1:0] o_dst_data
);
    typedef struct packed {
        logic         req;
        logic [W-1:0] hold;
    } seim_xsrc_t;

    typedef struct packed {
        logic         seen;
        logic         valid;
        logic [W-1:0] data;
    } seim_xdst_t;

    seim_xsrc_t src_reg;
    seim_xsrc_t src_next;
    seim_xdst_t dst_reg;
    seim_xdst_t dst_next;
    logic       req_s;
    logic       ack_s;

    seim_sync #(.W(1)) u_req_sync (
        .i_clk    (i_dst_clk),
        .i_arst_n (i_arst_n),
        .i_d      (src_reg.req),
        .o_q      (req_s)
    );

    seim_sync #(.W(1)) u_ack_sync (
        .i_clk    (i_src_clk),
        .i_arst_n (i_arst_n),
        .i_d      (dst_reg.seen),
        .o_q      (ack_s)
    );

    // hold stays still until the toggle comes back, so dst may sample it
    assign o_src_ready = (src_reg.req == ack_s);

    always_comb begin
        src_next = src_reg;
        if (i_src_valid && o_src_ready) begin
            src_next.hold = i_src_data;
            src_next.req  = ~src_reg.req;
        end
    end

    always_comb begin
        dst_next       = dst_reg;
        dst_next.valid = 1'b0;
        if (req_s != dst_reg.seen) begin
            dst_next.seen  = req_s;
            dst_next.valid = 1'b1;
            dst_next.data  = src_reg.hold;
        end
    end

    always_ff @(posedge i_src_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            src_reg <= '0;
        end else begin
            src_reg <= src_next;
        end
    end

    always_ff @(posedge i_dst_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dst_reg <= '0;
        end else begin
            dst_reg <= dst_next;
        end
    end

    assign o_dst_valid = dst_reg.valid;
    assign o_dst_data  = dst_reg.data;
endmodule // seim_xfer
`default_nettype wire

// file: verif/seim_checker.sv
// seim_checker: concurrent checks on the event logic pins
`timescale 1ns/1ns
`default_nettype none
module seim_checker
    import seim_pkg::*;
(
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    // events
    input  wire seim_meas_t [SEIM_NPROX-1:0] i_prox,
    input  wire seim_meas_t                 i_amb_vis,
    input  wire seim_meas_t                 i_amb_ir,
    input  wire logic                       i_resp_wr,
    // pin and flags
    input  wire logic                       o_int_out,
    input  wire logic                       o_int_oe,
    input  wire logic [SEIM_NFLAG-1:0]      o_flags
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////
    AST_PIN_LOW: assert property (o_int_out == 1'b0)
        else $error("pin output value not low");
    AST_OE_CAUSE: assert property (o_int_oe |-> $past(o_flags) != '0)
        else $error("pin driven with no flag set");
    AST_PROX1_CAUSE: assert property ($rose(o_flags[2]) |-> $past(i_prox[0].done))
        else $error("first proximity flag without sample");
    AST_PROX2_CAUSE: assert property ($rose(o_flags[3]) |-> $past(i_prox[1].done))
        else $error("second proximity flag without sample");
    AST_PROX3_CAUSE: assert property ($rose(o_flags[4]) |-> $past(i_prox[2].done))
        else $error("third proximity flag without sample");
    AST_CMD_CAUSE: assert property ($rose(o_flags[5]) |-> $past(i_resp_wr))
        else $error("command flag without response write");
    AST_AMB_CAUSE: assert property ($rose(o_flags[0]) || $rose(o_flags[1])
        |-> $past(i_amb_vis.done || i_amb_ir.done))
        else $error("ambient flag without sample");
    // a host clear needs a full link round trip, so two cycles is safe
    AST_CMD_STICKY: assert property ($rose(o_flags[5]) |=> o_flags[5] [*2])
        else $error("command flag dropped on its own");
endmodule // seim_checker
`default_nettype wire

// file: verif/seim_host.sv
// seim_host: host model on the register port and the pulled-up pin
`timescale 1ns/1ns
`default_nettype none
module seim_host
    import seim_pkg::*;
(
    // register port
    input  wire logic       i_link_clk,
    input  wire logic       i_link_busy,
    input  wire logic [7:0] i_link_rdata,
    output logic            o_link_wr,
    output logic            o_link_rd,
    output logic      [7:0] o_link_addr,
    output logic      [7:0] o_link_wdata,
    // interrupt pin
    input  wire logic       i_int_oe,
    output logic            o_pin
);
    // pull-up: the pin reads high unless the device sinks it
    assign o_pin = i_int_oe ? 1'b0 : 1'b1;
    initial begin
        o_link_wr = 1'b0;
        o_link_rd = 1'b0;
        o_link_addr = 8'hA5;
        o_link_wdata = 8'h5A;
    end
    task automatic wait_idle();
        int n;
        n = 0;
        while (i_link_busy !== 1'b0 && n < 200) begin
            @(negedge i_link_clk);
            n++;
        end
    endtask
    // idle lines show the inverse so stale data is never read as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_link_clk);
        wait_idle();
        o_link_addr = a;
        o_link_wdata = d;
        o_link_wr = 1'b1;
        @(negedge i_link_clk);
        o_link_wr = 1'b0;
        o_link_addr = ~a;
        o_link_wdata = ~d;
        @(negedge i_link_clk);
        wait_idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_link_clk);
        o_link_addr = a;
        o_link_rd = 1'b1;
        @(negedge i_link_clk);
        d = i_link_rdata;
        o_link_rd = 1'b0;
        o_link_addr = ~a;
    endtask
    task automatic clr(input logic [7:0] m);
        wr(SEIM_OFF_STATUS, m);
    endtask
endmodule // seim_host
`default_nettype wire

// file: verif/seim_tb.sv
// testbench: directed scenarios for the event enable and mode logic
`timescale 1ns/1ns
`default_nettype none
module testbench
    import seim_pkg::*;
;
    logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0;
    logic wr, rd, busy, resp_wr, oe, iout;
    logic [7:0] addr, wdata, rdata, resp_d;
    logic [SEIM_NFLAG-1:0] flags;
    seim_meas_t [SEIM_NPROX-1:0] prox;
    seim_meas_t vis, ir;
    logic [SEIM_NPROX-1:0][SEIM_DW-1:0] thr;
    logic [SEIM_DW-1:0] lo, hi;
    int num_errors = 0, n_checks = 0;
    always #20 clk = ~clk;
    initial begin
        #3;
        forever begin
            #7 lclk = 1'b1;
            #8 lclk = 1'b0;
        end
    end
    seim_top dut_u (.i_clk(clk), .i_arst_n(rst_n), .i_link_clk(lclk),
        .i_link_wr(wr), .i_link_rd(rd), .i_link_addr(addr),
        .i_link_wdata(wdata), .o_link_rdata(rdata), .o_link_busy(busy),
        .i_prox(prox), .i_prox_thr(thr), .i_amb_vis(vis), .i_amb_ir(ir),
        .i_amb_low(lo), .i_amb_high(hi), .i_resp_wr(resp_wr),
        .i_resp_data(resp_d), .o_int_out(iout), .o_int_oe(oe),
        .o_flags(flags));
    seim_host host_u (.i_link_clk(lclk), .i_link_busy(busy),
        .i_link_rdata(rdata), .o_link_wr(wr), .o_link_rd(rd),
        .o_link_addr(addr), .o_link_wdata(wdata), .i_int_oe(oe),
        .o_pin());
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // src: 0..2 proximity, 3 visible, 4 infrared, 5 response write
    task automatic fire(input int src, input logic [15:0] v,
                        input logic [7:0] r);
        @(negedge clk);
        for (int c = 0; c < 3; c++) prox[c] = '{done: (src == c), value: v};
        vis = '{done: (src == 3), value: v};
        ir = '{done: (src == 4), value: v};
        resp_wr = (src == 5);
        resp_d = r;
        @(negedge clk);
        for (int c = 0; c < 3; c++) prox[c].done = 1'b0;
        vis.done = 1'b0;
        ir.done = 1'b0;
        resp_wr = 1'b0;
    endtask
    task automatic step(input logic [7:0] en, input logic [7:0] ma,
                        input logic [7:0] mb, input int src,
                        input logic [15:0] v, input logic [7:0] r,
                        input logic [7:0] exp);
        logic [7:0] d;
        host_u.wr(SEIM_OFF_ENABLE, en);
        host_u.wr(SEIM_OFF_MODE_A, ma);
        host_u.wr(SEIM_OFF_MODE_B, mb);
        host_u.clr(8'h3F);
        fire(src, v, r);
        @(negedge clk);
        chk({2'b00, flags}, exp);
        chk({7'd0, host_u.o_pin}, {7'd0, exp == 8'h00});
        repeat (4) @(negedge clk);
        host_u.rd(SEIM_OFF_STATUS, d);
        chk(d, exp);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic regs();
        logic [7:0] a [4] = '{8'h04, 8'h05, 8'h06, 8'h10};
        logic [7:0] k [4] = '{8'h3F, 8'hF7, 8'h0F, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            host_u.rd(a[i], d);
            chk(d, 8'h00);
            host_u.wr(a[i], 8'hFF);
            host_u.rd(a[i], d);
            chk(d, k[i]);
        end
        host_u.wr(SEIM_OFF_CFG, 8'h01);
    endtask
    // crossing first, so the state seen after reset is below threshold
    task automatic prox_modes();
        logic [1:0] m [8] = '{1, 1, 1, 3, 3, 2, 0, 0};
        logic [15:0] v [8] = '{16'h0032, 16'h0096, 16'h0032, 16'h0096,
                               16'h0032, 16'h0096, 16'h0032, 16'h0032};
        bit e [8] = '{0, 1, 1, 1, 0, 0, 1, 0};
        logic [7:0] b, ma, mb;
        for (int ch = 0; ch < 3; ch++) begin
            b = 8'h04 << ch;
            for (int i = 0; i < 8; i++) begin
                ma = (ch == 0) ? {2'b00, m[i], 4'h0} :
                     (ch == 1) ? {m[i], 6'h00} : 8'h00;
                mb = (ch == 2) ? {6'h00, m[i]} : 8'h00;
                step(i < 7 ? b : 8'h00, ma, mb, ch, v[i], 8'h00,
                     e[i] ? b : 8'h00);
            end
        end
    endtask
    task automatic hold_and_gate();
        host_u.wr(SEIM_OFF_ENABLE, 8'h24);
        host_u.wr(SEIM_OFF_MODE_B, 8'h00);
        fire(5, 16'h0000, 8'h01);
        fire(0, 16'h0032, 8'h00);
        host_u.clr(8'h20);
        chk({7'd0, host_u.o_pin}, 8'h00);
        host_u.clr(8'h04);
        repeat (3) @(negedge clk);
        chk({7'd0, host_u.o_pin}, 8'h01);
        host_u.wr(SEIM_OFF_CFG, 8'h02);
        fire(0, 16'h0032, 8'h00);
        @(negedge clk);
        chk({2'b00, flags}, 8'h04);
        chk({7'd0, host_u.o_pin}, 8'h01);
        host_u.wr(SEIM_OFF_MODE_A, 8'h30);
        fire(0, 16'h0032, 8'h00);
        chk({2'b00, flags}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        prox = '0;
        vis = '0;
        ir = '0;
        resp_wr = 1'b0;
        resp_d = 8'h00;
        thr = {3{16'h0064}};
        lo = 16'h0064;
        hi = 16'h00C8;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'd0, host_u.o_pin}, 8'h01);
        regs();
        prox_modes();
        step(8'h01, 8'h00, 8'h00, 3, 16'h0096, 8'h00, 8'h01);
        step(8'h00, 8'h00, 8'h00, 3, 16'h0096, 8'h00, 8'h00);
        step(8'h01, 8'h01, 8'h00, 3, 16'h0096, 8'h00, 8'h00);
        step(8'h01, 8'h01, 8'h00, 3, 16'h0032, 8'h00, 8'h01);
        step(8'h01, 8'h03, 8'h00, 4, 16'h0096, 8'h00, 8'h00);
        step(8'h01, 8'h03, 8'h00, 4, 16'h0032, 8'h00, 8'h01);
        step(8'h02, 8'h04, 8'h00, 3, 16'h0032, 8'h00, 8'h00);
        step(8'h02, 8'h04, 8'h00, 3, 16'h0096, 8'h00, 8'h02);
        step(8'h02, 8'h06, 8'h00, 4, 16'h0096, 8'h00, 8'h02);
        step(8'h20, 8'h00, 8'h00, 5, 16'h0000, 8'h01, 8'h20);
        step(8'h00, 8'h00, 8'h00, 5, 16'h0000, 8'h81, 8'h00);
        step(8'h20, 8'h00, 8'h04, 5, 16'h0000, 8'h01, 8'h00);
        step(8'h20, 8'h00, 8'h04, 5, 16'h0000, 8'h81, 8'h20);
        step(8'h20, 8'h00, 8'h08, 5, 16'h0000, 8'h81, 8'h00);
        hold_and_gate();
        complete_run();
    end
    // the full run needs well under 200 us
    initial begin
        #2_000_000;
        num_errors++;
        complete_run();
    end
endmodule // testbench
bind seim_top seim_checker chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_prox(i_prox), .i_amb_vis(i_amb_vis), .i_amb_ir(i_amb_ir),
    .i_resp_wr(i_resp_wr), .o_int_out(o_int_out), .o_int_oe(o_int_oe),
    .o_flags(o_flags));
`default_nettype wire
